// ### core/chan_cfg_pkg.sv
// Package for the per-channel repeater configuration register set.
//
// How it works
// - Override bit selects register mute over auto.
// - Mute select set mutes output into idle.
// - Detect codes 00/11 fix termination, no probing.
// - Code 01 probes every 12 ms, 50 tries.
// - Code 10 probes every 12 ms until found.
// - Written detect field beats the detect pin.
// - Equalizer level eight bits, reset 0x2F.
// - Swing bit 7 drives short-circuit protection, reset 0xAD.
// - Generation bit: 1 first/second, 0 third.
// - Swing code 000..111 is 0.7..1.4 V.
// - De-emphasis bit 7 reads far-end detected.
// - Bits 6:5 read detected link generation.
// - Generation status meaningful only in automatic mode.
// - De-emphasis code at bits 2:0, reset 010.
// - Idle assert 3:2, de-assert 1:0, reset 00.
// - Written thresholds beat the threshold pin.
// - Force-off bit forces signal detect inactive.
// - Force-on bit forces signal detect active.
// - Registers addressed by byte register number.
package chan_cfg_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_IDLE_DETECT = 8'h32;
  localparam logic [7:0] ADDR_EQ_LEVEL    = 8'h33;
  localparam logic [7:0] ADDR_SWING       = 8'h34;
  localparam logic [7:0] ADDR_DEEMPH      = 8'h35;
  localparam logic [7:0] ADDR_IDLE_THRESH = 8'h36;
  localparam logic [7:0] ADDR_RESERVED    = 8'h37;
  localparam logic [7:0] ADDR_SIG_FORCE   = 8'h38;

  localparam logic [7:0] RST_IDLE_DETECT = 8'h00;
  localparam logic [7:0] RST_EQ_LEVEL    = 8'h2F;
  localparam logic [7:0] RST_SWING       = 8'hAD;
  localparam logic [7:0] RST_DEEMPH      = 8'h02;
  localparam logic [7:0] RST_IDLE_THRESH = 8'h00;
  localparam logic [7:0] RST_SIG_FORCE   = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int IDLE_OVR_BIT   = 5;
  localparam int MUTE_SEL_BIT   = 4;
  localparam int DET_MODE_LSB   = 2;
  localparam int SHORT_PROT_BIT = 7;
  localparam int GEN_SEL_BIT    = 6;
  localparam int SWING_LSB      = 0;
  localparam int DETECTED_BIT   = 7;
  localparam int GEN_STAT_LSB   = 5;
  localparam int DEEMPH_LSB     = 0;
  localparam int THR_ASSERT_LSB = 2;
  localparam int THR_DEASSERT_LSB = 0;
  localparam int FORCE_OFF_BIT  = 2;
  localparam int FORCE_ON_BIT   = 1;

  // ****************************************
  // Far-end detect codes and timing
  // ****************************************
  localparam logic [1:0] DET_HIGH_Z    = 2'h0;
  localparam logic [1:0] DET_LIMITED   = 2'h1;
  localparam logic [1:0] DET_UNLIMITED = 2'h2;
  localparam logic [1:0] DET_FIXED_50  = 2'h3;
  localparam int PROBE_PERIOD_MS = 12;
  localparam int CLK_KHZ         = 250000;
  localparam int PROBE_CYCLES    = PROBE_PERIOD_MS * CLK_KHZ;
  localparam int PROBE_TRIES     = 50;

  // Register request from the bus protocol engine or EEPROM loader.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ### core/chan_cfg_regs.sv
// Channel configuration and status registers of the repeater.
`timescale 1ns/1ns
module chan_cfg_regs #(
  parameter int unsigned PROBE_CYCLES = chan_cfg_pkg::PROBE_CYCLES
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Register access from the management bus engine
  input  wire chan_cfg_pkg::reg_req_t req_i,
  output logic                       rd_valid_o,
  output logic [7:0]                 rdata_o,
  // Configuration pins
  input  wire logic [1:0]            det_mode_pin_i,
  input  wire logic [3:0]            thresh_pin_i,
  input  wire logic                  mode_pin_auto_i,
  // Analog status
  input  wire logic                  auto_idle_i,
  input  wire logic                  far_end_present_i,
  input  wire logic [1:0]            gen_detected_i,
  input  wire logic                  next_sig_detect_i,
  // Channel controls
  output logic                       out_mute_o,
  output logic                       probe_pulse_o,
  output logic                       term_50ohm_o,
  output logic [7:0]                 eq_boost_o,
  output logic                       short_prot_o,
  output logic                       gen_low_rate_o,
  output logic [2:0]                 swing_level_o,
  output logic [2:0]                 deemph_level_o,
  output logic [1:0]                 thr_assert_o,
  output logic [1:0]                 thr_deassert_o,
  // Next channel signal detect
  output logic                       next_sig_detect_o
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] det_pin_meta_ff;
  logic [1:0] det_pin_ff;
  logic [3:0] thr_pin_meta_ff;
  logic [3:0] thr_pin_ff;
  logic       mode_auto_meta_ff;
  logic       mode_auto_ff;
  logic       idle_meta_ff;
  logic       idle_ff;
  logic       present_meta_ff;
  logic       present_ff;
  logic [1:0] gen_meta_ff;
  logic [1:0] gen_ff;
  logic       sd_meta_ff;
  logic       sd_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      det_pin_meta_ff   <= 2'h0;
      det_pin_ff        <= 2'h0;
      thr_pin_meta_ff   <= 4'h0;
      thr_pin_ff        <= 4'h0;
      mode_auto_meta_ff <= 1'b0;
      mode_auto_ff      <= 1'b0;
      idle_meta_ff      <= 1'b0;
      idle_ff           <= 1'b0;
      present_meta_ff   <= 1'b0;
      present_ff        <= 1'b0;
      gen_meta_ff       <= 2'h0;
      gen_ff            <= 2'h0;
      sd_meta_ff        <= 1'b0;
      sd_ff             <= 1'b0;
    end else begin
      det_pin_meta_ff   <= det_mode_pin_i;
      det_pin_ff        <= det_pin_meta_ff;
      thr_pin_meta_ff   <= thresh_pin_i;
      thr_pin_ff        <= thr_pin_meta_ff;
      mode_auto_meta_ff <= mode_pin_auto_i;
      mode_auto_ff      <= mode_auto_meta_ff;
      idle_meta_ff      <= auto_idle_i;
      idle_ff           <= idle_meta_ff;
      present_meta_ff   <= far_end_present_i;
      present_ff        <= present_meta_ff;
      gen_meta_ff       <= gen_detected_i;
      gen_ff            <= gen_meta_ff;
      sd_meta_ff        <= next_sig_detect_i;
      sd_ff             <= sd_meta_ff;
    end
  end

  // ****************************************
  // Writable registers
  // ****************************************
  logic [7:0] idle_detect_ff;
  logic [7:0] eq_level_ff;
  logic [7:0] swing_ff;
  logic [2:0] deemph_ff;
  logic [3:0] thresh_ff;
  logic [2:0] sig_force_ff;
  logic       det_written_ff;
  logic       thr_written_ff;

  // Reserved bits are not stored and read back as zero, except swing bits 5:3, which are stored as written.
  // Configuration loads from the EEPROM arrive on this same write port.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_detect_ff <= chan_cfg_pkg::RST_IDLE_DETECT;
      eq_level_ff    <= chan_cfg_pkg::RST_EQ_LEVEL;
      swing_ff       <= chan_cfg_pkg::RST_SWING;
      deemph_ff      <= chan_cfg_pkg::RST_DEEMPH[2:0];
      thresh_ff      <= chan_cfg_pkg::RST_IDLE_THRESH[3:0];
      sig_force_ff   <= chan_cfg_pkg::RST_SIG_FORCE[2:0];
    end else if (req_i.wr) begin
      unique case (req_i.addr)
        chan_cfg_pkg::ADDR_IDLE_DETECT:
          idle_detect_ff <= {2'h0, req_i.wdata[5:2], 2'h0};
        chan_cfg_pkg::ADDR_EQ_LEVEL:
          eq_level_ff <= req_i.wdata;
        chan_cfg_pkg::ADDR_SWING:
          swing_ff <= req_i.wdata;
        chan_cfg_pkg::ADDR_DEEMPH:
          deemph_ff <= req_i.wdata[2:0];
        chan_cfg_pkg::ADDR_IDLE_THRESH:
          thresh_ff <= req_i.wdata[3:0];
        chan_cfg_pkg::ADDR_SIG_FORCE:
          sig_force_ff <= {req_i.wdata[2:1], 1'b0};
        default: begin
        end
      endcase
    end
  end

  // A field follows its pin until software first writes its register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      det_written_ff <= 1'b0;
      thr_written_ff <= 1'b0;
    end else if (req_i.wr) begin
      if (req_i.addr == chan_cfg_pkg::ADDR_IDLE_DETECT) begin
        det_written_ff <= 1'b1;
      end
      if (req_i.addr == chan_cfg_pkg::ADDR_IDLE_THRESH) begin
        thr_written_ff <= 1'b1;
      end
    end
  end

  // ****************************************
  // Effective settings
  // ****************************************
  // The register wins for good once written, so a pin that moves later
  // cannot pull a field back to its strapped value.
  logic [1:0] nxt_det_mode;
  logic [3:0] nxt_thresh;

  always_comb begin
    nxt_det_mode = det_pin_ff;
    if (det_written_ff) begin
      nxt_det_mode = idle_detect_ff[chan_cfg_pkg::DET_MODE_LSB +: 2];
    end
    nxt_thresh = thr_pin_ff;
    if (thr_written_ff) begin
      nxt_thresh = thresh_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_mute_o     <= 1'b0;
      eq_boost_o     <= chan_cfg_pkg::RST_EQ_LEVEL;
      short_prot_o   <= chan_cfg_pkg::RST_SWING[chan_cfg_pkg::SHORT_PROT_BIT];
      gen_low_rate_o <= chan_cfg_pkg::RST_SWING[chan_cfg_pkg::GEN_SEL_BIT];
      swing_level_o  <= chan_cfg_pkg::RST_SWING[2:0];
      deemph_level_o <= chan_cfg_pkg::RST_DEEMPH[2:0];
      thr_assert_o   <= 2'h0;
      thr_deassert_o <= 2'h0;
    end else begin
      if (idle_detect_ff[chan_cfg_pkg::IDLE_OVR_BIT]) begin
        out_mute_o <= idle_detect_ff[chan_cfg_pkg::MUTE_SEL_BIT];
      end else begin
        out_mute_o <= idle_ff;
      end
      eq_boost_o     <= eq_level_ff;
      short_prot_o   <= swing_ff[chan_cfg_pkg::SHORT_PROT_BIT];
      gen_low_rate_o <= swing_ff[chan_cfg_pkg::GEN_SEL_BIT];
      swing_level_o  <= swing_ff[chan_cfg_pkg::SWING_LSB +: 3];
      deemph_level_o <= deemph_ff;
      thr_assert_o   <=
        nxt_thresh[chan_cfg_pkg::THR_ASSERT_LSB +: 2];
      thr_deassert_o <=
        nxt_thresh[chan_cfg_pkg::THR_DEASSERT_LSB +: 2];
    end
  end

  // ****************************************
  // Far-end receiver detection
  // ****************************************
  typedef enum logic [1:0] {
    DET_OFF,
    DET_PROBING,
    DET_FOUND,
    DET_GAVE_UP
  } det_state_t;

  det_state_t det_state_ff;
  logic [1:0] det_mode_ff;
  logic [21:0] probe_cnt_ff;
  logic [5:0]  tries_ff;
  logic        probe_wait_ff;

  localparam logic [21:0] PROBE_LAST = 22'(PROBE_CYCLES - 1);
  localparam logic [5:0]  TRIES_MAX  = 6'(chan_cfg_pkg::PROBE_TRIES);

  // The probe result is sampled one cycle after each pulse, which gives
  // the analog detector its response time without an extra handshake.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      det_state_ff  <= DET_OFF;
      det_mode_ff   <= chan_cfg_pkg::DET_HIGH_Z;
      probe_cnt_ff  <= 22'h0;
      tries_ff      <= 6'h0;
      probe_wait_ff <= 1'b0;
      probe_pulse_o <= 1'b0;
    end else begin
      det_mode_ff   <= nxt_det_mode;
      probe_pulse_o <= 1'b0;
      probe_wait_ff <= 1'b0;
      if (nxt_det_mode != det_mode_ff) begin
        probe_cnt_ff <= 22'h0;
        tries_ff     <= 6'h0;
        if (nxt_det_mode == chan_cfg_pkg::DET_LIMITED ||
            nxt_det_mode == chan_cfg_pkg::DET_UNLIMITED) begin
          det_state_ff <= DET_PROBING;
        end else begin
          det_state_ff <= DET_OFF;
        end
      end else begin
        unique case (det_state_ff)
          DET_PROBING: begin
            if (probe_wait_ff && present_ff) begin
              det_state_ff <= DET_FOUND;
            end else if (probe_wait_ff && det_mode_ff ==
                         chan_cfg_pkg::DET_LIMITED &&
                         tries_ff == TRIES_MAX) begin
              det_state_ff <= DET_GAVE_UP;
            end else if (probe_cnt_ff == PROBE_LAST) begin
              probe_cnt_ff  <= 22'h0;
              probe_pulse_o <= 1'b1;
              probe_wait_ff <= 1'b1;
              if (tries_ff != TRIES_MAX) begin
                tries_ff <= tries_ff + 6'h1;
              end
            end else begin
              probe_cnt_ff <= probe_cnt_ff + 22'h1;
            end
          end
          DET_OFF,
          DET_FOUND,
          DET_GAVE_UP: begin
            probe_cnt_ff <= 22'h0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      term_50ohm_o <= 1'b0;
    end else begin
      term_50ohm_o <= (det_mode_ff == chan_cfg_pkg::DET_FIXED_50) ||
                      (det_state_ff == DET_FOUND);
    end
  end

  // ****************************************
  // Status capture
  // ****************************************
  logic       detected_ff;
  logic [1:0] gen_status_ff;

  // Generation status only tracks in automatic mode; outside it the
  // value left over carries no meaning.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      detected_ff   <= 1'b0;
      gen_status_ff <= 2'h0;
    end else begin
      detected_ff <= (det_state_ff == DET_FOUND);
      if (mode_auto_ff) begin
        gen_status_ff <= gen_ff;
      end
    end
  end

  // ****************************************
  // Next channel signal detect
  // ****************************************
  // Force-off is tested first, so setting both force bits keeps the
  // next channel's signal detect inactive.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      next_sig_detect_o <= 1'b0;
    end else if (sig_force_ff[chan_cfg_pkg::FORCE_OFF_BIT]) begin
      next_sig_detect_o <= 1'b0;
    end else if (sig_force_ff[chan_cfg_pkg::FORCE_ON_BIT]) begin
      next_sig_detect_o <= 1'b1;
    end else begin
      next_sig_detect_o <= sd_ff;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Read data is taken from the registers before a write in the same
  // cycle lands, so a simultaneous write and read returns the old value.
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 8'h00;
    unique case (req_i.addr)
      chan_cfg_pkg::ADDR_IDLE_DETECT: nxt_rdata = idle_detect_ff;
      chan_cfg_pkg::ADDR_EQ_LEVEL:    nxt_rdata = eq_level_ff;
      chan_cfg_pkg::ADDR_SWING:       nxt_rdata = swing_ff;
      chan_cfg_pkg::ADDR_DEEMPH:
        nxt_rdata = {detected_ff, gen_status_ff, 2'h0, deemph_ff};
      chan_cfg_pkg::ADDR_IDLE_THRESH: nxt_rdata = {4'h0, thresh_ff};
      chan_cfg_pkg::ADDR_SIG_FORCE:   nxt_rdata = {5'h00, sig_force_ff};
      default:                        nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_valid_o <= 1'b0;
      rdata_o    <= 8'h00;
    end else begin
      rd_valid_o <= req_i.rd;
      if (req_i.rd) begin
        rdata_o <= nxt_rdata;
      end
    end
  end

endmodule

// ### bench/chan_cfg_regs_asserts.sv
// Concurrent checks on the channel configuration register ports.
`timescale 1ns/1ns
module chan_cfg_regs_asserts #(
  parameter int unsigned PROBE_CYCLES = 20
) (
  // Clock and reset
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  // Register port
  input wire chan_cfg_pkg::reg_req_t req_i,
  input wire logic                   rd_valid_o,
  // Channel controls
  input wire logic                   out_mute_o,
  input wire logic                   probe_pulse_o,
  input wire logic                   term_50ohm_o,
  input wire logic [7:0]             eq_boost_o,
  input wire logic                   short_prot_o,
  input wire logic                   gen_low_rate_o,
  input wire logic [2:0]             swing_level_o,
  input wire logic [2:0]             deemph_level_o,
  input wire logic [1:0]             thr_assert_o,
  input wire logic [1:0]             thr_deassert_o,
  input wire logic                   next_sig_detect_o
);
  wire         wr_ctl = req_i.wr && req_i.addr == 8'h32;
  wire         wr_eq  = req_i.wr && req_i.addr == 8'h33;
  wire         wr_swg = req_i.wr && req_i.addr == 8'h34;
  wire         wr_dem = req_i.wr && req_i.addr == 8'h35;
  wire         wr_thr = req_i.wr && req_i.addr == 8'h36;
  wire         wr_frc = req_i.wr && req_i.addr == 8'h38;
  logic [31:0] gap_ff;
  logic        armed_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A control write may restart probing, so the gap is judged again
  // only after a fresh pulse has been seen.
  always_ff @(posedge clk_i) begin
    if (rst_i || wr_ctl) begin
      gap_ff   <= 32'h0;
      armed_ff <= 1'h0;
    end else if (probe_pulse_o) begin
      gap_ff   <= 32'h0;
      armed_ff <= 1'h1;
    end else begin
      gap_ff   <= gap_ff + 32'h1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_read_answer: assert property (
    1'h1 |=> rd_valid_o == $past(req_i.rd))
    else $error("read answer out of step");
  a_eq_write: assert property (
    wr_eq |=> ##1 eq_boost_o == $past(req_i.wdata, 2))
    else $error("equalizer output wrong");
  a_swing_write: assert property (
    wr_swg |=> ##1 {short_prot_o, gen_low_rate_o, swing_level_o} ==
      {$past(req_i.wdata[7:6], 2), $past(req_i.wdata[2:0], 2)})
    else $error("swing outputs wrong");
  a_deemph_write: assert property (
    wr_dem |=> ##1 deemph_level_o == $past(req_i.wdata[2:0], 2))
    else $error("de-emphasis output wrong");
  a_thr_write: assert property (
    wr_thr |=> ##1 {thr_assert_o, thr_deassert_o} ==
      $past(req_i.wdata[3:0], 2))
    else $error("threshold outputs wrong");
  a_force_off: assert property (
    wr_frc && req_i.wdata[2] |=> ##1 !next_sig_detect_o)
    else $error("signal detect not forced off");
  a_mute_ovr: assert property (
    wr_ctl && req_i.wdata[5] |=> ##1 out_mute_o == $past(req_i.wdata[4], 2))
    else $error("mute override ignored");
  a_term_fixed: assert property (
    wr_ctl && req_i.wdata[3:2] == 2'h3 |=> ##[1:6] term_50ohm_o)
    else $error("fixed termination missing");
  // The gap counter restarts on a pulse and is read on the next one,
  // so a full probe period shows up as PROBE_CYCLES - 1 counts.
  a_probe_gap: assert property (
    probe_pulse_o && armed_ff |-> gap_ff == PROBE_CYCLES - 1)
    else $error("probe spacing wrong");

  cover property (probe_pulse_o);
  cover property ($rose(term_50ohm_o));
  cover property (wr_ctl && req_i.wdata[5]);
endmodule

// ### bench/mgmt_host_model.sv
// Management host model that issues single-byte register requests.
`timescale 1ns/1ns
module mgmt_host_model (
  // Clock
  input  wire logic              clk_i,
  // Register request
  output chan_cfg_pkg::reg_req_t req_o
);
  initial req_o = '0;

  function automatic logic [7:0] legal(input logic [7:0] a,
                                       input logic [7:0] d);
    case (a)
      8'h32: legal = d & 8'h3C;
      8'h34: legal = d & 8'hC7 | 8'h28;
      8'h35: legal = d & 8'h07;
      8'h36: legal = d & 8'h0F;
      8'h37: legal = 8'h00;
      8'h38: legal = d & 8'h06;
      default: legal = d;
    endcase
  endfunction

  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{wr: w, rd: !w, addr: a, wdata: legal(a, d)};
    @(posedge clk_i);
    // Idle lines show the inverse so a stale byte cannot pass for a new one.
    req_o <= '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
  endtask
endmodule

// ### bench/repeater_channel_config_regs_tb.sv
// Self-checking bench for the channel configuration registers.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module repeater_channel_config_regs_tb;
  localparam int P = 20;
  logic                   clk_i = 1'h0;
  logic                   rst_i = 1'h1;
  chan_cfg_pkg::reg_req_t req_i;
  logic [1:0]             det_mode_pin_i = 2'h3;
  logic [3:0]             thresh_pin_i = 4'hB;
  logic                   mode_pin_auto_i = 1'h0;
  logic                   auto_idle_i = 1'h0;
  logic                   far_end_present_i = 1'h0;
  logic [1:0]             gen_detected_i = 2'h3;
  logic                   next_sig_detect_i = 1'h0;
  logic                   rd_valid_o, out_mute_o, probe_pulse_o;
  logic                   term_50ohm_o, short_prot_o, gen_low_rate_o;
  logic                   next_sig_detect_o;
  logic [7:0]             rdata_o, eq_boost_o, d, e, exp_rd;
  logic [2:0]             swing_level_o, deemph_level_o;
  logic [1:0]             thr_assert_o, thr_deassert_o;
  logic [7:0]             expq[$];
  logic [7:0]             dflt[8] = '{8'h00, 8'h2F, 8'hAD, 8'h02,
                                      8'h00, 8'h00, 8'h00, 8'h00};
  int                     n_fail = 0, compares = 0, pulses = 0, k;
  int unsigned            seed = 20;
  wire [4:0]              swg = {short_prot_o, gen_low_rate_o, swing_level_o};
  wire [3:0]              thr = {thr_assert_o, thr_deassert_o};

  chan_cfg_regs #(.PROBE_CYCLES(P)) chan_cfg_regs_i (
    .clk_i, .rst_i, .req_i, .rd_valid_o, .rdata_o, .det_mode_pin_i,
    .thresh_pin_i, .mode_pin_auto_i, .auto_idle_i, .far_end_present_i,
    .gen_detected_i, .next_sig_detect_i, .out_mute_o, .probe_pulse_o,
    .term_50ohm_o, .eq_boost_o, .short_prot_o, .gen_low_rate_o,
    .swing_level_o, .deemph_level_o, .thr_assert_o, .thr_deassert_o,
    .next_sig_detect_o);
  mgmt_host_model mgmt_host_model_i (.clk_i, .req_o(req_i));

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    mgmt_host_model_i.xfer(1'h1, a, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    expq.push_back(v);
    mgmt_host_model_i.xfer(1'h0, a, 8'h00);
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial forever #2 clk_i = ~clk_i;

  // Read answers are judged here, in the order the reads were issued.
  always @(posedge clk_i) begin
    if (probe_pulse_o === 1'h1) pulses++;
    if (rd_valid_o === 1'h1) begin
      exp_rd = expq.size() ? expq.pop_front() : 8'hXX;
      `CHK("rdata", exp_rd, rdata_o)
    end
  end

  initial begin
    cyc(20000);
    n_fail++;
    tally_and_finish();
  end

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    cyc(6);
    `CHK("eq", 8'h2F, eq_boost_o)
    `CHK("swing", 5'h15, swg)
    `CHK("dem", 3'h2, deemph_level_o)
    `CHK("thr", 4'hB, thr)
    `CHK("term", 1'h1, term_50ohm_o)
    wr(8'h40, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      rd(i == 7 ? 8'h40 : 8'h32 + i[7:0], dflt[i]);
    end
    repeat (4) begin
      d = rnd();
      wr(8'h33, d);
      rd(8'h33, d);
      `CHK("eq", d, eq_boost_o)
    end
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      d[2:0] = i[2:0];
      e = d & 8'hC7 | 8'h28;
      wr(8'h34, d);
      rd(8'h34, e);
      `CHK("swing", ({e[7:6], e[2:0]}), swg)
    end
    for (int i = 0; i < 8; i++) begin
      wr(8'h35, 8'hF8 | i[7:0]);
      rd(8'h35, i[7:0]);
      `CHK("dem", i[2:0], deemph_level_o)
    end
    wr(8'h36, 8'h64);
    rd(8'h36, 8'h04);
    `CHK("thr", 4'h4, thr)
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      next_sig_detect_i <= d[0];
      wr(8'h38, {5'h00, i[1:0], 1'h0});
      cyc(6);
      `CHK("sd", i[1] ? 1'h0 : i[0] | d[0], next_sig_detect_o)
    end
    for (int i = 0; i < 8; i++) begin
      auto_idle_i <= i[0];
      wr(8'h32, {2'h0, i[2:1], 4'h0});
      cyc(6);
      `CHK("mute", i[2] ? i[1] : i[0], out_mute_o)
    end
    `CHK("term", 1'h0, term_50ohm_o)
    mode_pin_auto_i <= 1'h1;
    cyc(6);
    rd(8'h35, 8'h67);
    wr(8'h32, 8'h0C);
    cyc(6);
    `CHK("term", 1'h1, term_50ohm_o)
    pulses = 0;
    wr(8'h32, 8'h08);
    cyc(73);
    `CHK("probes", 3, pulses)
    `CHK("term", 1'h0, term_50ohm_o)
    far_end_present_i <= 1'h1;
    for (k = 0; k < 3 * P && term_50ohm_o !== 1'h1; k++) cyc(1);
    if (k == 3 * P) begin
      n_fail++;
      tally_and_finish();
    end
    rd(8'h35, 8'hE7);
    far_end_present_i <= 1'h0;
    wr(8'h32, 8'h00);
    pulses = 0;
    wr(8'h32, 8'h04);
    cyc(55 * (P + 1));
    `CHK("probes", 50, pulses)
    `CHK("term", 1'h0, term_50ohm_o)
    cyc(4);
    tally_and_finish();
  end
endmodule

bind chan_cfg_regs chan_cfg_regs_asserts #(.PROBE_CYCLES(PROBE_CYCLES))
  chan_cfg_regs_asserts_i (
  .clk_i, .rst_i, .req_i, .rd_valid_o, .out_mute_o, .probe_pulse_o,
  .term_50ohm_o, .eq_boost_o, .short_prot_o, .gen_low_rate_o,
  .swing_level_o, .deemph_level_o, .thr_assert_o, .thr_deassert_o,
  .next_sig_detect_o);
